// [window_supervisor_cfg.svh]
/*
 Constants of the window supervisor: register offsets, field positions, reset values and timing.
 Assumes a 100 MHz core clock and byte addresses on a 32-bit APB.
*/
`ifndef WINDOW_SUPERVISOR_CFG_SVH
`define WINDOW_SUPERVISOR_CFG_SVH

`define CORE_CLK_MHZ 100
`define WD_CYCLE_SHORT_US 100
`define WD_CYCLE_LONG_US 1000
`define WD_CYCLE_SHORT_CLKS (`WD_CYCLE_SHORT_US * `CORE_CLK_MHZ)
`define WD_CYCLE_LONG_CLKS (`WD_CYCLE_LONG_US * `CORE_CLK_MHZ)
`define LONG_OPEN_CYCLES 10'h258
`define PIN_SAMPLE_US 200
`define PIN_SAMPLE_CLKS (`PIN_SAMPLE_US * `CORE_CLK_MHZ)
`define RESET_DELAY_US 10000
`define RESET_DELAY_CLKS (`RESET_DELAY_US * `CORE_CLK_MHZ)

`define ADDR_CONTROL 6'h00
`define ADDR_SERIAL_TRIGGER 6'h01
`define ADDR_STATUS 6'h02
`define ADDR_EVENTS 6'h03

`define CTRL_PIN_SEL 0
`define CTRL_CYCLE_SEL 1
`define CTRL_OPEN_LSB 8
`define CTRL_CLOSED_LSB 16
`define CTRL_THRESH_LSB 24

`define OPEN_CYCLES_RESET 8'h0A
`define CLOSED_CYCLES_RESET 8'h0A
`define THRESHOLD_RESET 4'h8
`define FAIL_STEP_UP 6'h02
`define FAIL_MAX 6'h1F
`define PIN_TRIGGER_PATTERN 4'hC
`define INIT_FAIL_LIMIT 2'h2

`endif

// [window_supervisor_pkg.sv]
/*
 Types of the window supervisor: window and reset sequencing states.
 Assumes the constants header is included by the design file.
*/
`default_nettype none
package window_supervisor_pkg;
   typedef enum logic [1:0] {WIN_OFF, WIN_LONG, WIN_CLOSED, WIN_OPEN} win_state_t;
   typedef enum logic [1:0] {RST_HOLD, RST_RUN, RST_FAILSAFE} rst_state_t;
endpackage : window_supervisor_pkg
`default_nettype wire

// [window_supervisor.sv]
/*
 Window watchdog sequencing with reset escalation, reached over APB.
 Assumes a 100 MHz core clock, an asynchronous trigger pin and a wake pulse from the device state logic.
*/
// Local design decisions: the register addresses and register access over APB.
`include "window_supervisor_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module window_supervisor
   import window_supervisor_pkg::*;
#(
   parameter int unsigned CYCLE_SHORT_CLKS = `WD_CYCLE_SHORT_CLKS,
   parameter int unsigned CYCLE_LONG_CLKS = `WD_CYCLE_LONG_CLKS,
   parameter int unsigned SAMPLE_CLKS = `PIN_SAMPLE_CLKS,
   parameter int unsigned RESET_DELAY_CLKS = `RESET_DELAY_CLKS
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic triggerInputPin,
   input wire logic wakeStart,
   output logic resetOutput,
   output logic regulatorsOn,
   output logic failsafeReq,
   output logic normalAllowed,
   output logic windowResultValid,
   output logic windowResultInvalid,
   output logic eventIrq
);

   win_state_t winState_reg;
   win_state_t winState_next;
   rst_state_t rstState_reg;
   logic pinSel_reg;
   logic cycleSel_reg;
   logic [7:0] openCycles_reg;
   logic [7:0] closedCycles_reg;
   logic [3:0] threshold_reg;
   logic [2:0] events_reg;
   logic [19:0] prescale_reg;
   logic [9:0] ticks_reg;
   logic [19:0] sampleCnt_reg;
   logic [19:0] holdCnt_reg;
   logic pinS1_reg;
   logic pinS2_reg;
   logic pinS3_reg;
   logic pinLevel_reg;
   logic [2:0] pinHist_reg;
   logic [4:0] failCount_reg;
   logic [4:0] failCount_next;
   logic [1:0] initFails_reg;
   logic inInit_reg;
   logic resetOutput_reg;
   logic regulatorsOn_reg;
   logic normalAllowed_reg;
   logic validOut_reg;
   logic invalidOut_reg;
   logic eventOut_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   logic apbAccess;
   logic apbWrite;
   logic addrMapped;
   logic cycleTick;
   logic sampleTick;
   logic pinTrig;
   logic serialTrig;
   logic active;
   logic trigger;
   logic [9:0] winLen;
   logic winDone;
   logic validEv;
   logic invalidEv;
   logic openExpire;
   logic longInvalid;
   logic initFail;
   logic [5:0] failSum;
   logic thresholdHit;
   logic wakeAccept;
   logic startHold;
   logic goFailsafe;
   logic holdDone;
   logic releaseEv;
   logic restart;
   logic [31:0] statusWord;

   // The slave answers with no wait state, so pready is tied high through the whole access.
   assign apbAccess = psel && penable;
   assign apbWrite = apbAccess && pwrite;
   assign addrMapped = (paddr[7:2] <= `ADDR_EVENTS);
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   assign serialTrig = apbWrite && (paddr[7:2] == `ADDR_SERIAL_TRIGGER);
   assign active = (rstState_reg == RST_RUN) && (winState_reg != WIN_OFF) && !wakeAccept;
   assign trigger = active && (pinSel_reg ? pinTrig : serialTrig);

   // the second low sample after two highs takes effect.
   assign pinTrig = sampleTick && ({pinHist_reg, pinLevel_reg} == `PIN_TRIGGER_PATTERN);

   // the long window is a fixed count of cycle times, so the cycle select scales it.
   always_comb begin
      case (winState_reg)
         WIN_LONG: winLen = `LONG_OPEN_CYCLES;
         WIN_OPEN: winLen = {2'h0, openCycles_reg};
         WIN_CLOSED: winLen = {2'h0, closedCycles_reg};
         default: winLen = 10'h3FF;
      endcase
   end

   // a window ends on the tick that completes its count.
   assign winDone = cycleTick && ((ticks_reg + 10'h001) >= winLen);

   // valid trigger in long or open window.
   assign validEv = trigger && ((winState_reg == WIN_LONG) || (winState_reg == WIN_OPEN));
   assign openExpire = active && winDone && !trigger && (winState_reg == WIN_OPEN);
   assign longInvalid = active && winDone && !trigger && (winState_reg == WIN_LONG) && !inInit_reg;
   // expiry in the init phase counts as init timeout, with no event.
   assign initFail = active && winDone && !trigger && (winState_reg == WIN_LONG) && inInit_reg;
   // trigger in closed window is invalid.
   assign invalidEv = (trigger && (winState_reg == WIN_CLOSED)) || openExpire || longInvalid;

   assign failSum = {1'b0, failCount_reg} + `FAIL_STEP_UP;
   assign thresholdHit = invalidEv && (failSum >= {2'h0, threshold_reg});

   // wake is accepted only while the reset sequencing is in RST_RUN.
   assign wakeAccept = wakeStart && (rstState_reg == RST_RUN);
   assign startHold = thresholdHit || (initFail && (initFails_reg != `INIT_FAIL_LIMIT));
   assign goFailsafe = initFail && (initFails_reg == `INIT_FAIL_LIMIT);
   assign holdDone = (holdCnt_reg == 20'(RESET_DELAY_CLKS - 1));
   assign releaseEv = (rstState_reg == RST_HOLD) && holdDone;

   always_comb begin
      winState_next = winState_reg;
      if (releaseEv) begin
         winState_next = WIN_LONG;
      end else if ((rstState_reg != RST_RUN) || startHold || goFailsafe) begin
         winState_next = WIN_OFF;
      end else if (wakeAccept) begin
         winState_next = WIN_LONG;
      end else if (active) begin
         case (winState_reg)
            WIN_LONG: begin
               // long window ends early on a valid trigger.
               if (validEv) begin
                  winState_next = WIN_CLOSED;
               end else if (longInvalid) begin
                  winState_next = WIN_OPEN;
               end
            end
            WIN_OPEN: begin
               // closed window follows the valid trigger.
               if (validEv) begin
                  winState_next = WIN_CLOSED;
               end
            end
            WIN_CLOSED: begin
               // invalid trigger or expiry opens a window.
               if (trigger || winDone) begin
                  winState_next = WIN_OPEN;
               end
            end
            default: winState_next = WIN_OFF;
         endcase
      end
   end

   // a missed open window restarts the count in a fresh open window.
   assign restart = (winState_next != winState_reg) || openExpire;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         winState_reg <= WIN_OFF;
      end else begin
         winState_reg <= winState_next;
      end
   end

   // prescaler for the selected cycle time.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prescale_reg <= 20'h00000;
      end else if (restart || cycleTick) begin
         prescale_reg <= 20'h00000;
      end else begin
         prescale_reg <= prescale_reg + 20'h00001;
      end
   end
   assign cycleTick = cycleSel_reg ? (prescale_reg == 20'(CYCLE_LONG_CLKS - 1))
                                   : (prescale_reg == 20'(CYCLE_SHORT_CLKS - 1));

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ticks_reg <= 10'h000;
      end else if (restart) begin
         ticks_reg <= 10'h000;
      end else if (cycleTick) begin
         ticks_reg <= ticks_reg + 10'h001;
      end
   end

   // A pin change counts only once the second and third stages agree.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinS1_reg <= 1'b0;
         pinS2_reg <= 1'b0;
         pinS3_reg <= 1'b0;
         pinLevel_reg <= 1'b0;
      end else begin
         pinS1_reg <= triggerInputPin;
         pinS2_reg <= pinS1_reg;
         pinS3_reg <= pinS2_reg;
         if (pinS2_reg == pinS3_reg) begin
            pinLevel_reg <= pinS3_reg;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sampleCnt_reg <= 20'h00000;
      end else if (sampleTick) begin
         sampleCnt_reg <= 20'h00000;
      end else begin
         sampleCnt_reg <= sampleCnt_reg + 20'h00001;
      end
   end
   assign sampleTick = (sampleCnt_reg == 20'(SAMPLE_CLKS - 1));

   // every sample is kept, only a falling pattern matches; a rise alone never matches.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinHist_reg <= 3'h0;
      end else if (sampleTick) begin
         pinHist_reg <= {pinHist_reg[1:0], pinLevel_reg};
      end
   end

   // valid trigger decrements, never below zero.
   always_comb begin
      failCount_next = failCount_reg;
      if (thresholdHit) begin
         failCount_next = 5'h00;
      end else if (invalidEv) begin
         failCount_next = (failSum > `FAIL_MAX) ? 5'h1F : failSum[4:0];
      end else if (validEv && (failCount_reg != 5'h00)) begin
         failCount_next = failCount_reg - 5'h01;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         failCount_reg <= 5'h00;
      end else begin
         failCount_reg <= failCount_next;
      end
   end

   // Init failures are counted in a row, so any valid trigger forgives them.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         initFails_reg <= 2'h0;
         inInit_reg <= 1'b0;
      end else begin
         if (validEv) begin
            initFails_reg <= 2'h0;
         end else if (initFail) begin
            initFails_reg <= initFails_reg + 2'h1;
         end
         if (releaseEv) begin
            inInit_reg <= 1'b1;
         end else if (wakeAccept || validEv) begin
            inInit_reg <= 1'b0;
         end
      end
   end

   // reset output released after the delay.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rstState_reg <= RST_HOLD;
         holdCnt_reg <= 20'h00000;
         resetOutput_reg <= 1'b0;
         regulatorsOn_reg <= 1'b1;
      end else begin
         case (rstState_reg)
            RST_HOLD: begin
               holdCnt_reg <= holdCnt_reg + 20'h00001;
               if (holdDone) begin
                  rstState_reg <= RST_RUN;
                  resetOutput_reg <= 1'b1;
                  regulatorsOn_reg <= 1'b1;
               end
            end
            RST_RUN: begin
               holdCnt_reg <= 20'h00000;
               if (goFailsafe) begin
                  rstState_reg <= RST_FAILSAFE;
                  resetOutput_reg <= 1'b0;
                  regulatorsOn_reg <= 1'b0;
               end else if (startHold) begin
                  rstState_reg <= RST_HOLD;
                  resetOutput_reg <= 1'b0;
                  // second init failure switches the regulators off.
                  regulatorsOn_reg <= !(initFail && (initFails_reg == 2'h1));
               end
            end
            default: begin
               resetOutput_reg <= 1'b0;
               regulatorsOn_reg <= 1'b0;
            end
         endcase
      end
   end

   // first valid trigger allows normal state.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         normalAllowed_reg <= 1'b0;
      end else if (startHold || goFailsafe) begin
         normalAllowed_reg <= 1'b0;
      end else if (validEv) begin
         normalAllowed_reg <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         validOut_reg <= 1'b0;
         invalidOut_reg <= 1'b0;
         eventOut_reg <= 1'b0;
      end else begin
         validOut_reg <= validEv;
         invalidOut_reg <= invalidEv;
         eventOut_reg <= invalidEv || wakeAccept;
      end
   end

   assign resetOutput = resetOutput_reg;
   assign regulatorsOn = regulatorsOn_reg;
   assign failsafeReq = (rstState_reg == RST_FAILSAFE);
   assign normalAllowed = normalAllowed_reg;
   assign windowResultValid = validOut_reg;
   assign windowResultInvalid = invalidOut_reg;
   assign eventIrq = eventOut_reg;

   // Reconfiguration takes effect at once, also in the middle of the window that is running.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pinSel_reg <= 1'b0;
         cycleSel_reg <= 1'b1;
         openCycles_reg <= `OPEN_CYCLES_RESET;
         closedCycles_reg <= `CLOSED_CYCLES_RESET;
         threshold_reg <= `THRESHOLD_RESET;
      end else if (apbWrite && (paddr[7:2] == `ADDR_CONTROL)) begin
         pinSel_reg <= pwdata[`CTRL_PIN_SEL];
         cycleSel_reg <= pwdata[`CTRL_CYCLE_SEL];
         openCycles_reg <= pwdata[`CTRL_OPEN_LSB +: 8];
         closedCycles_reg <= pwdata[`CTRL_CLOSED_LSB +: 8];
         threshold_reg <= pwdata[`CTRL_THRESH_LSB +: 4];
      end
   end

   // Sticky events are cleared by writing one; a new event in the same cycle wins.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         events_reg <= 3'h0;
      end else begin
         if (apbWrite && (paddr[7:2] == `ADDR_EVENTS)) begin
            events_reg <= (events_reg & ~pwdata[2:0]) | {wakeAccept, validEv, invalidEv};
         end else begin
            events_reg <= events_reg | {wakeAccept, validEv, invalidEv};
         end
      end
   end

   assign statusWord = {19'h00000, resetOutput_reg, failsafeReq, initFails_reg, failCount_reg,
                        normalAllowed_reg, inInit_reg, winState_reg};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_reg <= !addrMapped || (pwrite && (paddr[7:2] == `ADDR_STATUS));
         case (paddr[7:2])
            `ADDR_CONTROL: prdata_reg <= {4'h0, threshold_reg, closedCycles_reg, openCycles_reg,
                                          6'h00, cycleSel_reg, pinSel_reg};
            `ADDR_STATUS: prdata_reg <= statusWord;
            `ADDR_EVENTS: prdata_reg <= {29'h00000000, events_reg};
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end

   sequence s_heldLow;
      !resetOutput[*8];
   endsequence

   sequence s_closedThenOpen;
      (winState_reg == WIN_CLOSED) ##1 (winState_reg == WIN_OPEN);
   endsequence

   a_long_start: assert property (@(posedge core_clk) disable iff (reset)
      $rose(resetOutput) |-> (winState_reg == WIN_LONG) && (ticks_reg == 10'h000))
      else $error("long window did not start at reset release");

   a_wake_event: assert property (@(posedge core_clk) disable iff (reset)
      wakeAccept |=> eventIrq && (winState_reg == WIN_LONG))
      else $error("wake did not open window with event");

   a_valid_closes: assert property (@(posedge core_clk) disable iff (reset)
      windowResultValid |-> (winState_reg == WIN_CLOSED) && normalAllowed && !eventIrq)
      else $error("valid trigger did not start closed window");

   a_no_rise: assert property (@(posedge core_clk) disable iff (reset)
      pinTrig |-> !pinLevel_reg && !pinHist_reg[0])
      else $error("pin trigger without low level");

   a_invalid_adds: assert property (@(posedge core_clk) disable iff (reset)
      invalidEv && !thresholdHit && (failCount_reg < 5'h1D) |=> failCount_reg == $past(failCount_reg) + 5'h02)
      else $error("invalid trigger did not add two");

   a_valid_dec: assert property (@(posedge core_clk) disable iff (reset)
      validEv |=> failCount_reg == (($past(failCount_reg) == 5'h00) ? 5'h00 : $past(failCount_reg) - 5'h01))
      else $error("valid trigger decrement wrong");

   a_threshold_reset: assert property (@(posedge core_clk) disable iff (reset)
      thresholdHit |=> !resetOutput ##0 (failCount_reg == 5'h00) ##0 (winState_reg == WIN_OFF))
      else $error("threshold did not issue reset");

   a_closed_cut: assert property (@(posedge core_clk) disable iff (reset)
      (trigger && (winState_reg == WIN_CLOSED) && !thresholdHit) |-> s_closedThenOpen ##0
      (windowResultInvalid && eventIrq))
      else $error("closed window not cut by invalid trigger");

   a_reset_delay: assert property (@(posedge core_clk) disable iff (reset)
      $fell(resetOutput) && !failsafeReq |-> s_heldLow)
      else $error("reset output released too early");

   a_failsafe: assert property (@(posedge core_clk) disable iff (reset)
      goFailsafe |=> (failsafeReq && !regulatorsOn && !resetOutput) [*3])
      else $error("failsafe not entered or not held");

endmodule : window_supervisor
`default_nettype wire

// [mcu_model.sv]
/*
 Model of the supervised controller that pulses the watchdog trigger pin.
 Assumes the bench requests each pulse with a one-cycle fire strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module mcu_model #(
   parameter int unsigned SAMPLE_CLKS = 3
) (
   input wire logic core_clk,
   input wire logic fire,
   output logic pin
);
   int unsigned left = 0;
   always_ff @(posedge core_clk) begin
      if (fire) begin
         left <= 8 * SAMPLE_CLKS;
      end else if (left != 0) begin
         left <= left - 1;
      end
   end
   // The pin idles low as its pull-down leaves it; four high samples give the sampler margin.
   assign pin = (left > 4 * SAMPLE_CLKS);
endmodule : mcu_model
`default_nettype wire

// [testbench.sv]
/*
 Self-checking bench of the window supervisor, run with short tick parameters.
 Assumes the supervisor, its package and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic wakeStart = 1'b0, fire = 1'b0, pin, pready, pslverr, er, resetOutput, regulatorsOn;
   logic failsafeReq, normalAllowed, windowResultValid, windowResultInvalid, eventIrq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   int n_errors = 0, n_tests = 0, nVal = 0, nInv = 0, nEvt = 0, v0, i0, e0, t;
   always #5 core_clk = ~core_clk;
   window_supervisor #(.CYCLE_SHORT_CLKS(4), .CYCLE_LONG_CLKS(8), .SAMPLE_CLKS(3), .RESET_DELAY_CLKS(10)) i_dut (
      .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .triggerInputPin(pin),
      .wakeStart(wakeStart), .resetOutput(resetOutput), .regulatorsOn(regulatorsOn), .failsafeReq(failsafeReq),
      .normalAllowed(normalAllowed), .windowResultValid(windowResultValid),
      .windowResultInvalid(windowResultInvalid), .eventIrq(eventIrq));
   mcu_model #(.SAMPLE_CLKS(3)) i_mcu (.core_clk(core_clk), .fire(fire), .pin(pin));
   always @(posedge core_clk) begin
      nVal <= nVal + int'(windowResultValid === 1'b1);
      nInv <= nInv + int'(windowResultInvalid === 1'b1);
      nEvt <= nEvt + int'(eventIrq === 1'b1);
   end
   task automatic give_verdict();
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic snap();
      v0 = nVal;
      i0 = nInv;
      e0 = nEvt;
   endtask : snap
   task automatic delta(input int dv, input int di, input int de);
      chk("valid pulses", 32'(nVal - v0), 32'(dv));
      chk("invalid pulses", 32'(nInv - i0), 32'(di));
      chk("event pulses", 32'(nEvt - e0), 32'(de));
   endtask : delta
   task automatic waitRst(input logic lvl, input int lim);
      for (t = 0; t < lim && resetOutput !== lvl; t++) @(posedge core_clk);
      chk("reset output wait", 32'(resetOutput), 32'(lvl));
   endtask : waitRst
   task automatic startup();
      waitRst(1'b1, 50);
      chk("release delay", 32'(t >= 9 && t <= 12), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("control reset", rd, 32'h080A0A02);
      apb(1'b0, 8'h08, 32'h0);
      chk("long window state", 32'(rd[2:0]), 32'h5);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error", 32'(er), 32'h1);
      apb(1'b1, 8'h08, 32'hFFFFFFFF);
      chk("status write error", 32'(er), 32'h1);
   endtask : startup
   task automatic serialFlow();
      apb(1'b1, 8'h00, 32'h080A0A00);
      snap();
      apb(1'b1, 8'h04, 32'h1);
      cyc(2);
      delta(1, 0, 0);
      apb(1'b0, 8'h08, 32'h0);
      chk("after valid", 32'({rd[8:3], rd[1:0]}), 32'h06);
      chk("normal allowed", 32'(normalAllowed), 32'h1);
      snap();
      apb(1'b1, 8'h04, 32'h1);
      cyc(2);
      delta(0, 1, 1);
      apb(1'b0, 8'h08, 32'h0);
      chk("after closed trigger", 32'({rd[8:3], rd[1:0]}), 32'h17);
      snap();
      apb(1'b1, 8'h04, 32'h1);
      for (t = 0; t < 200 && nInv == i0; t++) @(posedge core_clk);
      chk("closed plus open time", 32'(t >= 79 && t <= 84), 32'h1);
      delta(1, 1, 1);
      chk("below threshold", 32'(resetOutput), 32'h1);
   endtask : serialFlow
   task automatic pinFlow();
      apb(1'b1, 8'h00, 32'h080A0A01);
      snap();
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      cyc(10);
      delta(0, 0, 0);
      cyc(30);
      delta(1, 0, 0);
      snap();
      apb(1'b1, 8'h04, 32'h1);
      cyc(2);
      delta(0, 0, 0);
   endtask : pinFlow
   task automatic wakeThreshold();
      apb(1'b1, 8'h00, 32'h040A0A01);
      snap();
      wakeStart <= 1'b1;
      cyc(1);
      wakeStart <= 1'b0;
      cyc(2);
      delta(0, 0, 1);
      apb(1'b0, 8'h08, 32'h0);
      chk("wake window state", 32'(rd[1:0]), 32'h1);
      waitRst(1'b0, 3000);
      chk("short long window", 32'(t >= 2393 && t <= 2399), 32'h1);
      cyc(2);
      delta(0, 1, 2);
      chk("threshold reset", 32'(resetOutput), 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk("sticky events", rd, 32'h00000007);
      apb(1'b1, 8'h0C, 32'h00000005);
      apb(1'b0, 8'h0C, 32'h0);
      chk("events after clear", rd, 32'h00000002);
   endtask : wakeThreshold
   task automatic escalation();
      reset <= 1'b1;
      cyc(2);
      reset <= 1'b0;
      waitRst(1'b1, 50);
      snap();
      waitRst(1'b0, 6000);
      chk("long window length", 32'(t >= 4797 && t <= 4804), 32'h1);
      cyc(2);
      chk("soft reset supply", 32'(regulatorsOn), 32'h1);
      waitRst(1'b1, 50);
      chk("soft reset delay", 32'(t >= 8 && t <= 12), 32'h1);
      delta(0, 0, 0);
      apb(1'b0, 8'h08, 32'h0);
      chk("new long window", 32'(rd[1:0]), 32'h1);
      waitRst(1'b0, 6000);
      cyc(2);
      chk("hard reset supply", 32'(regulatorsOn), 32'h0);
      waitRst(1'b1, 50);
      cyc(4810);
      chk("failsafe", 32'(failsafeReq), 32'h1);
   endtask : escalation
   initial begin
      cyc(10);
      reset <= 1'b0;
      startup();
      serialFlow();
      pinFlow();
      wakeThreshold();
      escalation();
      give_verdict();
   end
   initial begin
      cyc(40000);
      n_errors++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
